/* File: spdif_pin_sync.sv */
/*
 * two flip-flop synchroniser with edge detection on the synchronised level.
 * assumes the input is asynchronous to i_core_clk.
 */
`timescale 1ns/1ps

module spdif_pin_sync (
	input  wire logic i_core_clk, // core clock
	input  wire logic i_reset,    // async reset, active high
	input  wire logic i_async,    // raw input
	output logic      o_level,    // synchronised level
	output logic      o_rise      // one-cycle pulse on rising edge
);

	logic meta_q; // first stage, read only by the second
	logic sync_q; // second stage
	logic prev_q; // last synchronised value

	// two stages then an edge detector on the second
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign o_level = sync_q;
	assign o_rise  = sync_q & ~prev_q;

endmodule // spdif_pin_sync

/* File: spdif_rx_status_flags.sv */
/*
 * receiver status flags: samples the decoder's sub-frame strobe on the
 * recovered link clock, derives lock, error, channel status, rate, phase,
 * block and update flags, raises an active-low interrupt and routes the
 * flags to selectable output pins and mode pins.
 * assumes decoder outputs are stable around the recovered clock rising edge
 * that closes a sub-frame, and a status read is a one-cycle core pulse.
 */
`timescale 1ns/1ps
`include "spdif_status_defines.svh"

module spdif_rx_status_flags
	import spdif_status_pkg::*;
(
	input  wire logic                    i_core_clk,       // core clock 250 MHz
	input  wire logic                    i_reset,          // async reset, active high
	input  wire logic                    i_link_clk,       // recovered link clock
	input  wire logic                    i_subframe_end,   // level: sub-frame done
	input  wire subframe_t               i_subframe,       // fields of that sub-frame
	input  wire logic                    i_pll_locked,     // clock recovery locked
	input  wire logic                    i_signal_present, // stream present
	input  wire logic                    i_biphase_err,    // coding error seen
	input  wire logic                    i_preamble_miss,  // preamble missing
	input  wire logic [1:0]              i_rate_detect,    // measured rate code
	input  wire logic                    i_dac_zero_detect, // zero detect from DACs
	input  wire logic                    i_hw_mode,        // hardware control mode
	input  wire logic                    i_status_read,    // status read pulse
	input  wire pin_sel_t [`NUM_PINS-1:0] i_pin_sel,       // per-pin source select
	output flags_t                       o_flags,          // status register view
	output logic [6:0]                   o_status_reg,     // packed status register
	output logic [`NUM_PINS-1:0]         o_status_out_pins, // selectable pins
	output logic                         o_control_mode_pin, // lock lost in hw mode
	output logic                         o_serial_out_pin, // not-audio in hw mode
	output logic                         o_mute_pin,       // zero detect
	output logic                         o_int_n           // interrupt, active low
);

	// synchronised level inputs
	logic lclk_rise; // one-cycle pulse on a link clock rising edge
	logic end_lvl, lock_lvl, pres_lvl, bph_lvl, pre_lvl, zero_lvl, hw_lvl;
	logic [1:0] rate_meta_q, rate_q;

	spdif_pin_sync u_lclk (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_async    (i_link_clk),
		.o_level    (),
		.o_rise     (lclk_rise)
	);

	// plain two-stage synchronisers for level inputs
	logic [6:0] lvl_meta_q, lvl_q;
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			lvl_meta_q  <= 7'h00;
			lvl_q       <= 7'h00;
			rate_meta_q <= 2'h0;
			rate_q      <= 2'h0;
		end else begin
			lvl_meta_q  <= {i_subframe_end, i_pll_locked, i_signal_present,
			                i_biphase_err, i_preamble_miss, i_dac_zero_detect, i_hw_mode};
			lvl_q       <= lvl_meta_q;
			rate_meta_q <= i_rate_detect;
			rate_q      <= rate_meta_q;
		end
	end
	assign {end_lvl, lock_lvl, pres_lvl, bph_lvl, pre_lvl, zero_lvl, hw_lvl} = lvl_q;

	// sub-frame fields are caught at the link edge when the strobe is seen
	logic      sf_take;
	subframe_t sf_q;      // stable copy for the whole sub-frame
	assign sf_take = lclk_rise & end_lvl;

	// per-sub-frame capture, updates only at a boundary
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			sf_q <= '0;
		end else if (sf_take) begin
			sf_q <= i_subframe;
		end
	end

	// even parity over the captured bits is checked by the caller supplying word
	function automatic logic parity_bad(input subframe_t s);
		parity_bad = ^{s.word, s.valid, s.user, s.chan, s.parity};
	endfunction

	// frame counter and channel status collection from sub-frame A
	logic [7:0]            frame_q;
	logic [`CS_BITS-1:0]   cs_shift_q, cs_block_q;
	logic                  block_q;      // high through frame 0
	logic                  updated_q;    // block channel status changed
	logic                  seq_err_q;    // two A or two B in a row
	logic                  par_err_q;    // parity failed on the last sub-frame
	logic                  last_a_q;

	// frame count, block marker and sequence
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			frame_q   <= 8'h00;
			block_q   <= 1'b0;
			last_a_q  <= 1'b0;
			seq_err_q <= 1'b0;
			par_err_q <= 1'b0;
		end else if (sf_take) begin
			last_a_q  <= i_subframe.is_a;
			seq_err_q <= (i_subframe.is_a == last_a_q);
			par_err_q <= parity_bad(i_subframe);
			if (i_subframe.is_a) begin
				if (i_subframe.blk_start) begin
					frame_q <= 8'h00;
					block_q <= 1'b1;
				end else begin
					frame_q <= (frame_q == `FRAME_LAST) ? 8'h00 : frame_q + 8'h01;
					block_q <= 1'b0;
				end
			end
		end
	end

	// channel status shift and per-block comparison
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			cs_shift_q <= '0;
			cs_block_q <= '0;
			updated_q  <= 1'b0;
		end else if (sf_take && i_subframe.is_a) begin
			if (i_subframe.blk_start) begin
				updated_q  <= (cs_shift_q != cs_block_q);
				cs_block_q <= cs_shift_q;
				cs_shift_q <= {{(`CS_BITS-1){1'b0}}, i_subframe.chan};
			end else begin
				if (frame_q < 8'(`CS_BITS - 1))
					cs_shift_q[frame_q[`CS_IDX_W-1:0] + 5'h01] <= i_subframe.chan;
				updated_q <= 1'b0;
			end
		end
	end

	// sync code detection over consecutive sub-frame words
	logic [15:0] prev_word_q;
	logic        compressed_q;
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			prev_word_q  <= 16'h0000;
			compressed_q <= 1'b0;
		end else if (sf_take) begin
			prev_word_q <= i_subframe.word;
			if (prev_word_q == `SYNC_PA && i_subframe.word == `SYNC_PB)
				compressed_q <= 1'b1;
			else if (i_subframe.blk_start && !i_subframe.chan)
				compressed_q <= 1'b0; // cleared when a block starts with channel status bit 0 low
		end
	end

	// flag set, updated every core cycle
	flags_t flags_d, flags_q;
	always_comb begin
		flags_d = flags_q;
		flags_d.lock_lost = ~(lock_lvl & pres_lvl);
		flags_d.recovered_rate = flags_d.lock_lost ? `RATE_INVALID : rate_q;
		// faults of the last sub-frame stand until the next one is taken
		flags_d.link_error = bph_lvl | pre_lvl | seq_err_q | par_err_q;
		if (sf_take) begin
			flags_d.validity_fail = i_subframe.valid;
		end
		flags_d.non_pcm            = cs_block_q[`CS_BIT_AUDIO_N];
		flags_d.copyright_free     = cs_block_q[`CS_BIT_COPYRIGHT_FREE];
		flags_d.preemphasis_marked = cs_block_q[`CS_BIT_PREEMPH];
		flags_d.compressed         = compressed_q;
		flags_d.status_block_updated = updated_q;
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset)
			flags_q <= '0;
		else
			flags_q <= flags_d;
	end

	// interrupt events: rising edges and any-change flags
	logic pend_q;
	logic ev;
	always_comb begin
		ev = (flags_d.validity_fail & ~flags_q.validity_fail)
		   | (flags_d.link_error & ~flags_q.link_error)
		   | (flags_d.status_block_updated & ~flags_q.status_block_updated)
		   | (flags_d.lock_lost != flags_q.lock_lost)
		   | ((flags_d.compressed | flags_d.non_pcm) != (flags_q.compressed | flags_q.non_pcm))
		   | (flags_d.copyright_free != flags_q.copyright_free)
		   | (flags_d.preemphasis_marked != flags_q.preemphasis_marked)
		   | (flags_d.recovered_rate != flags_q.recovered_rate);
	end

	// set wins over read; sticky sources keep it held
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset)
			pend_q <= 1'b0;
		else if (ev)
			pend_q <= 1'b1;
		else if (i_status_read)
			pend_q <= flags_q.validity_fail | flags_q.link_error
			        | flags_q.status_block_updated;
	end

	// pin source selection
	function automatic logic pick(input pin_sel_t s, input flags_t f, input subframe_t sf,
	                              input logic blk, input logic zero, input logic intn);
		unique case (s)
			SEL_LOCK_LOST:  pick = f.lock_lost;
			SEL_INT_N:      pick = intn;
			SEL_VALID:      pick = sf.valid;
			SEL_USER:       pick = sf.user;
			SEL_CHAN:       pick = sf.chan;
			SEL_PARITY:     pick = sf.parity;
			SEL_PHASE:      pick = sf.is_a;
			SEL_BLOCK:      pick = blk;
			SEL_UPDATED:    pick = f.status_block_updated;
			SEL_ZERO:       pick = zero;
			SEL_NOT_AUDIO:  pick = f.compressed | f.non_pcm;
			SEL_COPYRIGHT:  pick = f.copyright_free;
			SEL_PREEMPH:    pick = f.preemphasis_marked;
			SEL_VALID_FAIL: pick = f.validity_fail;
			SEL_LINK_ERR:   pick = f.link_error;
			SEL_LOW:        pick = 1'b0;
		endcase
	endfunction

	// registered outputs
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_flags            <= '0;
			o_status_reg       <= 7'h40;
			o_status_out_pins  <= '0;
			o_control_mode_pin <= 1'b0;
			o_serial_out_pin   <= 1'b0;
			o_mute_pin         <= 1'b0;
			o_int_n            <= 1'b1;
		end else begin
			o_flags      <= flags_q;
			o_status_reg <= {flags_q.lock_lost, flags_q.recovered_rate,
			                 flags_q.preemphasis_marked, flags_q.copyright_free,
			                 flags_q.compressed, flags_q.non_pcm};
			for (int i = 0; i < `NUM_PINS; i++)
				o_status_out_pins[i] <= pick(i_pin_sel[i], flags_q, sf_q, block_q,
				                             zero_lvl, ~pend_q);
			o_control_mode_pin <= hw_lvl & flags_q.lock_lost;
			o_serial_out_pin   <= hw_lvl & (flags_q.compressed | flags_q.non_pcm);
			o_mute_pin         <= zero_lvl;
			o_int_n            <= ~pend_q;
		end
	end

endmodule // spdif_rx_status_flags

/* File: spdif_rx_status_flags_properties.sv */
/* checker: port-level assertions for the receiver status flag block.
   assumes it is bound to spdif_rx_status_flags and sees only its ports. */
`timescale 1ns/1ps
module spdif_status_chk
	import spdif_status_pkg::*;
(
	input wire logic   i_core_clk,         // core clock
	input wire logic   i_reset,            // async reset, active high
	input wire logic   i_pll_locked,       // recovery locked
	input wire logic   i_signal_present,   // stream present
	input wire logic   i_dac_zero_detect,  // zero detect in
	input wire logic   i_hw_mode,          // hardware mode
	input wire logic   i_status_read,      // interrupt status read pulse
	input wire flags_t o_flags,            // flag view
	input wire logic [6:0] o_status_reg,   // packed status
	input wire logic   o_control_mode_pin, // mode pin
	input wire logic   o_serial_out_pin,   // data pin
	input wire logic   o_mute_pin,         // mute pin
	input wire logic   o_int_n             // interrupt, active low
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	AST_LOCKED: assert property ((i_pll_locked && i_signal_present)[*8] |-> !o_flags.lock_lost)
		else $error("lock flag high while locked");
	AST_UNLOCKED: assert property ((!i_pll_locked)[*8] |-> o_flags.lock_lost)
		else $error("lock flag low while unlocked");
	AST_RATE_INVALID: assert property (o_flags.lock_lost[*3] |-> o_flags.recovered_rate == 2'h0)
		else $error("rate code valid while unlocked");
	AST_CTRL_PIN: assert property ((i_hw_mode && $stable(o_flags))[*8] |-> o_control_mode_pin == o_flags.lock_lost)
		else $error("mode pin differs from lock flag");
	AST_SDO_PIN: assert property ((i_hw_mode && $stable(o_flags))[*8] |-> o_serial_out_pin == (o_flags.compressed | o_flags.non_pcm))
		else $error("data pin differs from not-audio");
	AST_HW_OFF: assert property ((!i_hw_mode)[*8] |-> !(o_control_mode_pin || o_serial_out_pin))
		else $error("mode pins driven outside hardware mode");
	AST_MUTE: assert property ($stable(i_dac_zero_detect)[*8] |-> o_mute_pin == i_dac_zero_detect)
		else $error("mute pin differs from zero detect");
	AST_STATUS_REG: assert property ($stable(o_flags)[*2] |-> o_status_reg == {o_flags.lock_lost, o_flags.recovered_rate, o_flags.preemphasis_marked, o_flags.copyright_free, o_flags.compressed, o_flags.non_pcm})
		else $error("status register differs from flags");
	AST_INT_VALID: assert property ($rose(o_flags.validity_fail) |-> ##[0:3] !o_int_n)
		else $error("no interrupt on validity rise");
	AST_INT_HOLD: assert property ((!o_int_n && !i_status_read)[*4] |=> !o_int_n)
		else $error("interrupt released without read");
endmodule // spdif_status_chk

bind spdif_rx_status_flags spdif_status_chk i_chk (.i_core_clk, .i_reset, .i_pll_locked,
	.i_signal_present, .i_dac_zero_detect, .i_hw_mode, .i_status_read, .o_flags, .o_status_reg,
	.o_control_mode_pin, .o_serial_out_pin, .o_mute_pin, .o_int_n);

/* File: spdif_source_model.sv */
/* far-side source: delivers decoded sub-frames with a recovered link clock.
   assumes calls come from the bench one at a time. */
`timescale 1ns/1ps
module spdif_source_model
	import spdif_status_pkg::*;
(
	output logic      o_link_clk,     // recovered clock, idles low
	output logic      o_subframe_end, // sub-frame closing level
	output subframe_t o_subframe      // sub-frame fields
);
	initial begin
		o_link_clk = 1'b0;
		o_subframe_end = 1'b0;
		o_subframe = '0;
	end
	// one sub-frame closed by one 40 ns link cycle; fields garbled afterwards
	task automatic send(input logic v, u, c, a, blk, bad, input logic [15:0] w);
		o_subframe = '{v, u, c, ^{w, v, u, c} ^ bad, a, blk, w}; // even parity unless bad
		o_subframe_end = 1'b1;
		#8 o_link_clk = 1'b1;
		#16 o_link_clk = 1'b0;
		#8 o_subframe_end = 1'b0;
		o_subframe = ~o_subframe;
		#8;
	endtask
endmodule // spdif_source_model

/* File: spdif_status_defines.svh */
/*
 * constants for the receiver status flag block: flag positions, rate codes,
 * block length, pin count and select width and the non-audio sync words.
 * assumes it is included by the package and the design modules by bare name.
 */
`ifndef SPDIF_STATUS_DEFINES_SVH
`define SPDIF_STATUS_DEFINES_SVH

`define FRAMES_PER_BLOCK 8'd192
`define FRAME_LAST       8'd191
`define CS_BIT_AUDIO_N   1
`define CS_BIT_COPYRIGHT_FREE     2
`define CS_BIT_PREEMPH   3
`define CS_BITS          32
`define CS_IDX_W         5
`define RATE_INVALID     2'h0
`define RATE_96K         2'h1
`define RATE_48K         2'h2
`define RATE_32K         2'h3
`define SYNC_PA          16'hF872
`define SYNC_PB          16'h4E1F
`define NUM_PINS         4
`define SEL_W            4
`define STAT_LOCK_LOST   6
`define STAT_RATE_LO     4
`define STAT_PREEMPH     3
`define STAT_CPY         2
`define STAT_PCM_N       1
`define STAT_AUDIO_N     0

`endif

/* File: spdif_status_pkg.sv */
/*
 * types for the receiver status flag block.
 * assumes spdif_status_defines.svh is on the include path.
 */
`include "spdif_status_defines.svh"

package spdif_status_pkg;

	// one received sub-frame as presented by the decoder
	typedef struct packed {
		logic        valid;     // validity bit
		logic        user;      // user bit
		logic        chan;      // channel status bit
		logic        parity;    // parity bit
		logic        is_a;      // sub-frame A (or block start B)
		logic        blk_start; // preamble marks frame 0
		logic [15:0] word;      // upper audio bits
	} subframe_t;

	// the collected status flags
	typedef struct packed {
		logic       lock_lost;
		logic       validity_fail;
		logic       link_error;
		logic       non_pcm;
		logic       compressed;
		logic       copyright_free;
		logic       preemphasis_marked;
		logic [1:0] recovered_rate;
		logic       status_block_updated;
	} flags_t;

	// selectable sources for a status output pin
	typedef enum logic [3:0] {
		SEL_LOCK_LOST, SEL_INT_N, SEL_VALID, SEL_USER, SEL_CHAN, SEL_PARITY,
		SEL_PHASE, SEL_BLOCK, SEL_UPDATED, SEL_ZERO, SEL_NOT_AUDIO, SEL_COPYRIGHT,
		SEL_PREEMPH, SEL_VALID_FAIL, SEL_LINK_ERR, SEL_LOW
	} pin_sel_t;

endpackage

/* File: test_spdif_rx_status_flags.sv */
/* self-checking bench for the receiver status flag block.
   assumes the checker is bound by its own file. */
`timescale 1ns/1ps
module test_spdif_rx_status_flags;
	import spdif_status_pkg::*;
	logic           core_clk = 1'b0, reset = 1'b1, pll = 1'b0, present = 1'b0;
	logic           berr = 1'b0, pmiss = 1'b0, zero = 1'b0, hw = 1'b0, rd = 1'b0;
	logic [1:0]     rate = 2'h2;
	pin_sel_t [3:0] sel = '{SEL_LOW, SEL_LOW, SEL_LOW, SEL_LOW};
	flags_t         flags;
	logic [6:0]     sreg;
	logic [3:0]     pins, cs_prev, cs_old;
	logic           cpin, spin, mpin, int_n, lclk, sf_end;
	subframe_t      sf;
	logic [15:0]    rnd = 16'hA7F1;
	logic [3:0]     cs_tab [3] = '{4'hE, 4'h4, 4'hA};
	int             mismatches = 0, num_checks = 0, cycles = 0;

	spdif_rx_status_flags i_dut (.i_core_clk(core_clk), .i_reset(reset), .i_link_clk(lclk),
		.i_subframe_end(sf_end), .i_subframe(sf), .i_pll_locked(pll), .i_signal_present(present),
		.i_biphase_err(berr), .i_preamble_miss(pmiss), .i_rate_detect(rate),
		.i_dac_zero_detect(zero), .i_hw_mode(hw), .i_status_read(rd), .i_pin_sel(sel),
		.o_flags(flags), .o_status_reg(sreg), .o_status_out_pins(pins),
		.o_control_mode_pin(cpin), .o_serial_out_pin(spin), .o_mute_pin(mpin), .o_int_n(int_n));
	spdif_source_model i_src (.o_link_clk(lclk), .o_subframe_end(sf_end), .o_subframe(sf));

	initial forever #2 core_clk = ~core_clk;
	// hang guard
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			end_sim();
		end
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic check(input logic [15:0] seen, exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic status_read();
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
		tick(4);
	endtask
	// one sub-frame, then the per-sub-frame checks of the pin set cfg
	task automatic sub(input logic v, a, f0, c, bad, input logic [15:0] w, input int cfg);
		logic u;
		rnd = lfsr(rnd);
		u = rnd[1];
		i_src.send(v, u, c, a, a & f0, bad, w);
		tick(1);
		check(flags.validity_fail, v, "validity flag");
		if (cfg == 0) check(pins, {^{w, v, u, c} ^ bad, c, u, v}, "vucp pins");
		if (cfg == 1) check(pins, {2'b00, f0, a}, "phase and block pins");
	endtask
	// a whole 192-frame block carrying status bits 0..3 in cs
	task automatic block(input logic [3:0] cs, input int cfg, input logic upd);
		for (int f = 0; f < 192; f++) begin
			sub(rnd[2], 1'b1, f == 0, f < 4 ? cs[f] : 1'b0, 1'b0, rnd, cfg);
			if (f == 0) check(flags.status_block_updated, upd, "block update");
			sub(rnd[2], 1'b0, f == 0, 1'b0, 1'b0, rnd, cfg);
		end
	endtask

	initial begin
		tick(2);
		reset = 1'b0;
		sel[0] = SEL_LOCK_LOST;
		for (int k = 0; k < 4; k++) begin
			{pll, present} = k[1:0];
			hw = k[0];
			tick(10);
			check({flags.lock_lost, flags.recovered_rate == 2'h0}, {2{k != 3}}, "lock flag");
			check({pins[0], sreg[6], cpin}, {k != 3, k != 3, k == 1}, "lock views");
		end
		for (int r = 0; r < 4; r++) begin
			rate = r[1:0];
			tick(10);
			check({flags.recovered_rate, sreg[5:4]}, {2{r[1:0]}}, "rate code");
		end
		sel[1] = SEL_ZERO;
		for (int z = 1; z >= 0; z--) begin
			zero = z[0];
			tick(10);
			check({mpin, pins[1]}, {2{z[0]}}, "zero views");
		end
		sel = '{SEL_PARITY, SEL_CHAN, SEL_USER, SEL_VALID};
		block(4'h0, 0, 1'b0);
		cs_prev = 4'h0;
		cs_old = 4'h0;
		for (int b = 0; b < 3; b++) begin
			if (b == 1) sel = '{SEL_LOW, SEL_LOW, SEL_BLOCK, SEL_PHASE};
			else sel = '{SEL_PARITY, SEL_CHAN, SEL_USER, SEL_VALID};
			block(cs_tab[b], b % 2, cs_prev != cs_old);
			check({flags.preemphasis_marked, flags.copyright_free, flags.non_pcm, sreg[3:2], sreg[0]},
				{2{cs_prev[3:1]}}, "status bits");
			check({spin, flags.link_error}, {cs_prev[1], 1'b0}, "not-audio pin");
			sel = '{SEL_PREEMPH, SEL_COPYRIGHT, SEL_NOT_AUDIO, SEL_UPDATED};
			tick(2);
			check(pins, {cs_prev[3:1], 1'b0}, "status pins");
			cs_old = cs_prev;
			cs_prev = cs_tab[b];
		end
		sel[0] = SEL_LINK_ERR;
		for (int k = 0; k < 4; k++) begin
			sub(1'b0, k != 3, 1'b0, 1'b0, 1'b0, rnd, 2);
			berr = (k == 2);
			pmiss = (k == 1);
			sub(1'b0, 1'b0, 1'b0, 1'b0, k == 0, rnd, 2);
			check({flags.link_error, pins[0]}, 2'b11, "link fault");
			berr = 1'b0;
			pmiss = 1'b0;
		end
		sub(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'hF872, 2);
		sub(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h4E1F, 2);
		sub(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, rnd, 2);
		check({flags.compressed, sreg[1], spin}, 3'b111, "sync code");
		sub(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, rnd, 2);
		sel[2] = SEL_INT_N;
		sel[1] = SEL_VALID_FAIL;
		status_read();
		status_read();
		check(int_n, 1'b1, "interrupt idle");
		sub(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, rnd, 2);
		check({int_n, pins[2:1]}, 3'b001, "validity interrupt");
		status_read();
		check(int_n, 1'b0, "sticky validity");
		sub(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, rnd, 2);
		status_read();
		check({int_n, pins[2:1]}, 3'b110, "interrupt released");
		end_sim();
	end
endmodule // test_spdif_rx_status_flags
